// ---- rtl/arx_regs.vh ----
// Purpose: constants for the audio receive data, word mask and master clock control block
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes: one receive channel, two words per frame
`ifndef ARX_REGS_VH
`define ARX_REGS_VH

// register byte offsets
`define ARX_OFF_RDATA 9'h0A0
`define ARX_OFF_WMASK 9'h0E0
`define ARX_OFF_CTRL 9'h008
`define ARX_OFF_CFG3 9'h00C
`define ARX_OFF_STAT 9'h010
`define ARX_OFF_IMASK 9'h014
`define ARX_OFF_MCTRL 9'h100
`define ARX_OFF_MDIV 9'h104

// field positions
`define ARX_MC_DUF 31
`define ARX_MC_MOE 30
`define ARX_MC_SEL_HI 25
`define ARX_MC_SEL_LO 24
`define ARX_CTRL_RE 0
`define ARX_CFG3_CE 0
`define ARX_ST_WORD 0
`define ARX_ST_OVF 1
`define ARX_ST_FEND 2

// reset values
`define ARX_RST_WMASK 2'h0
`define ARX_RST_SEL 2'h0
`define ARX_RST_RATIO 8'h01
`define ARX_RST_STAT 3'h0

// timing: one wait state on receive data reads
`define ARX_RD_WAIT 1'b1

`endif

// ---- rtl/arx_mclk_div.v ----
// Purpose: master clock divider with on-the-fly ratio update and clean shutdown
// Assumes: src_i is already synchronised to clk_i
// Notes: counts rising edges of the selected source
`timescale 1ns/1ps
`include "arx_regs.vh"
module arx_mclk_div (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // control
   input wire en_i,
   input wire src_i,
   input wire [7:0] ratio_i,
   input wire load_i,
   // status and clock out
   output reg mclk_o,
   output wire busy_o,
   output wire active_o
);
   reg src_q;
   reg run_q;
   reg pend_q;
   reg [7:0] ratio_q;
   reg [7:0] cnt_q;
   wire rise;
   wire tick;

   assign rise = src_i & ~src_q;
   assign tick = rise & (cnt_q >= ratio_q - 8'h01);
   assign busy_o = pend_q;
   assign active_o = run_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         src_q <= 1'b0;
         run_q <= 1'b0;
         pend_q <= 1'b0;
         ratio_q <= `ARX_RST_RATIO;
         cnt_q <= 8'h00;
         mclk_o <= 1'b0;
      end else begin
         src_q <= src_i;
         if (en_i) begin
            run_q <= 1'b1;
         end else if (run_q && !mclk_o) begin
            run_q <= 1'b0;
         end
         if (load_i && !pend_q) begin
            pend_q <= 1'b1;
         end
         if (!run_q) begin
            cnt_q <= 8'h00;
            mclk_o <= 1'b0;
            ratio_q <= ratio_i;
            pend_q <= 1'b0;
         end else if (tick) begin
            cnt_q <= 8'h00;
            mclk_o <= en_i ? ~mclk_o : 1'b0;
            if (pend_q) begin
               ratio_q <= ratio_i;
               pend_q <= 1'b0;
            end
         end else if (rise) begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
endmodule

// ---- rtl/arx_top.v ----
// Purpose: receive data port, receive word mask and master clock control
// Assumes: receiver word strobes and frame end come from logic on SYS_CLK_I
// Notes: master clock sources and pin input are sampled by two flip-flops
`timescale 1ns/1ps
`include "arx_regs.vh"
module arx_top (
   // clock and reset
   input wire SYS_CLK_I,
   input wire SYS_RST_I,
   // wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [8:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // receiver word stream
   input wire RX_WORD_STB_I,
   input wire [31:0] RX_WORD_I,
   input wire RX_FRAME_END_I,
   output wire RX_ENABLE_O,
   output wire RX_CHAN_EN_O,
   // master clock sources and pin
   input wire [3:0] MCLK_SRC_I,
   input wire MCLK_I,
   output wire MCLK_O,
   output wire MCLK_OE_O,
   output wire MCLK_INT_O,
   // interrupt
   output wire IRQ_O
);
   // software state
   reg [1:0] wmask_q;
   reg [1:0] wmask_act_q;
   reg re_q;
   reg re_prev_q;
   reg ce_q;
   reg [2:0] stat_q;
   reg [2:0] stat_d;
   reg [2:0] imask_q;
   reg moe_q;
   reg [1:0] sel_q;
   reg [7:0] ratio_q;
   reg div_load_q;
   // receive FIFO, one word deep
   reg [31:0] fifo_mem [0:0];
   reg full_q;
   reg full_d;
   reg pos_q;
   // bus handshake
   reg wait_q;
   reg ack_d;
   reg [31:0] rdata_d;
   // synchronisers
   reg [3:0] src_s1_q;
   reg [3:0] src_s2_q;
   reg pin_s1_q;
   reg pin_s2_q;
   // divider
   wire div_clk;
   wire div_busy;
   wire div_active;
   wire src_sel;
   wire moe_rd;
   // decode
   wire req;
   wire wr;
   wire rd_data;
   wire word_in;
   wire word_keep;
   wire pop;
   wire ovf;

   function hit;
      input [8:0] adr;
      input [8:0] off;
      begin
         hit = (adr[8:2] == off[8:2]);
      end
   endfunction

   assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wr = ack_d & WB_WE_I;
   assign rd_data = hit(WB_ADR_I, `ARX_OFF_RDATA) & ~WB_WE_I;

   // one extra wait state on receive data reads
   always @* begin
      ack_d = 1'b0;
      if (req) begin
         if (rd_data) begin
            ack_d = wait_q;
         end else begin
            ack_d = 1'b1;
         end
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         wait_q <= 1'b0;
         WB_ACK_O <= 1'b0;
      end else begin
         wait_q <= req & rd_data & ~wait_q & `ARX_RD_WAIT;
         WB_ACK_O <= ack_d;
      end
   end

   // receive path
   assign word_in = RX_WORD_STB_I & re_q & ce_q;
   assign word_keep = word_in & ~wmask_act_q[pos_q];
   assign pop = ack_d & rd_data & full_q;
   assign ovf = word_keep & full_q & ~pop;

   always @* begin
      full_d = full_q;
      if (pop) begin
         full_d = 1'b0;
      end
      if (word_keep && (!full_q || pop)) begin
         full_d = 1'b1;
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (word_keep && (!full_q || pop)) begin
         fifo_mem[0] <= RX_WORD_I;
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         full_q <= 1'b0;
         pos_q <= 1'b0;
         wmask_act_q <= `ARX_RST_WMASK;
         re_prev_q <= 1'b0;
      end else begin
         full_q <= full_d;
         re_prev_q <= re_q;
         if (RX_FRAME_END_I || !re_q) begin
            pos_q <= 1'b0;
         end else if (word_in) begin
            pos_q <= ~pos_q;
         end
         if ((re_q && !re_prev_q) || (RX_FRAME_END_I && re_q)) begin
            wmask_act_q <= wmask_q;
         end
      end
   end

   // status flags: hardware set wins over write-one-to-clear
   always @* begin
      stat_d = stat_q;
      if (wr && hit(WB_ADR_I, `ARX_OFF_STAT) && WB_SEL_I[0]) begin
         stat_d = stat_q & ~WB_DAT_I[2:0];
      end
      if (word_keep) begin
         stat_d[`ARX_ST_WORD] = 1'b1;
      end
      if (ovf) begin
         stat_d[`ARX_ST_OVF] = 1'b1;
      end
      if (RX_FRAME_END_I && re_q) begin
         stat_d[`ARX_ST_FEND] = 1'b1;
      end
   end

   assign IRQ_O = |(stat_q & imask_q);

   // register writes
   always @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         wmask_q <= `ARX_RST_WMASK;
         re_q <= 1'b0;
         ce_q <= 1'b0;
         stat_q <= `ARX_RST_STAT;
         imask_q <= 3'h0;
         moe_q <= 1'b0;
         sel_q <= `ARX_RST_SEL;
         ratio_q <= `ARX_RST_RATIO;
         div_load_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         div_load_q <= 1'b0;
         if (wr && WB_SEL_I[0]) begin
            if (hit(WB_ADR_I, `ARX_OFF_WMASK)) begin
               wmask_q <= WB_DAT_I[1:0];
            end
            if (hit(WB_ADR_I, `ARX_OFF_CTRL)) begin
               re_q <= WB_DAT_I[`ARX_CTRL_RE];
            end
            if (hit(WB_ADR_I, `ARX_OFF_CFG3)) begin
               ce_q <= WB_DAT_I[`ARX_CFG3_CE];
            end
            if (hit(WB_ADR_I, `ARX_OFF_IMASK)) begin
               imask_q <= WB_DAT_I[2:0];
            end
            if (hit(WB_ADR_I, `ARX_OFF_MDIV) && !div_busy) begin
               ratio_q <= WB_DAT_I[7:0];
               div_load_q <= div_active;
            end
         end
         if (wr && WB_SEL_I[3] && hit(WB_ADR_I, `ARX_OFF_MCTRL)) begin
            moe_q <= WB_DAT_I[`ARX_MC_MOE];
            if (!moe_rd) begin
               sel_q <= WB_DAT_I[`ARX_MC_SEL_HI:`ARX_MC_SEL_LO];
            end
         end
      end
   end

   // read data, registered with the ack
   assign moe_rd = moe_q | div_active;

   always @* begin
      rdata_d = 32'h00000000;
      if (hit(WB_ADR_I, `ARX_OFF_RDATA)) begin
         rdata_d = full_q ? fifo_mem[0] : 32'h00000000;
      end else if (hit(WB_ADR_I, `ARX_OFF_WMASK)) begin
         rdata_d[1:0] = wmask_q;
      end else if (hit(WB_ADR_I, `ARX_OFF_CTRL)) begin
         rdata_d[`ARX_CTRL_RE] = re_q;
      end else if (hit(WB_ADR_I, `ARX_OFF_CFG3)) begin
         rdata_d[`ARX_CFG3_CE] = ce_q;
      end else if (hit(WB_ADR_I, `ARX_OFF_STAT)) begin
         rdata_d[2:0] = stat_q;
      end else if (hit(WB_ADR_I, `ARX_OFF_IMASK)) begin
         rdata_d[2:0] = imask_q;
      end else if (hit(WB_ADR_I, `ARX_OFF_MCTRL)) begin
         rdata_d[`ARX_MC_DUF] = div_busy;
         rdata_d[`ARX_MC_MOE] = moe_rd;
         rdata_d[`ARX_MC_SEL_HI:`ARX_MC_SEL_LO] = sel_q;
      end else if (hit(WB_ADR_I, `ARX_OFF_MDIV)) begin
         rdata_d[7:0] = ratio_q;
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         WB_DAT_O <= 32'h00000000;
      end else if (ack_d && !WB_WE_I) begin
         WB_DAT_O <= rdata_d;
      end
   end

   // two-flop sampling of clock sources and the pin
   always @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         src_s1_q <= 4'h0;
         src_s2_q <= 4'h0;
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         src_s1_q <= MCLK_SRC_I;
         src_s2_q <= src_s1_q;
         pin_s1_q <= MCLK_I;
         pin_s2_q <= pin_s1_q;
      end
   end

   assign src_sel = src_s2_q[sel_q];

   arx_mclk_div u_div (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .en_i(moe_q),
      .src_i(src_sel),
      .ratio_i(ratio_q),
      .load_i(div_load_q),
      .mclk_o(div_clk),
      .busy_o(div_busy),
      .active_o(div_active)
   );

   assign MCLK_OE_O = div_active;
   assign MCLK_O = div_clk;
   assign MCLK_INT_O = div_active ? div_clk : pin_s2_q;
   assign RX_ENABLE_O = re_q;
   assign RX_CHAN_EN_O = ce_q;
endmodule

// ---- sim/arx_codec_model.sv ----
// Purpose: far-side model: receiver word stream and master clock sources
// Assumes: words and frame ends arrive on the system clock
// Notes: data line shows the inverse of the last word once released
`timescale 1ns/1ps
module arx_codec_model (
   // clock
   input wire clk_i,
   // word stream
   output reg stb_o,
   output reg [31:0] word_o,
   output reg fend_o,
   // clock sources and pin
   output reg [3:0] src_o,
   output reg pin_o
);
   initial begin
      stb_o = 1'b0;
      word_o = 32'h0;
      fend_o = 1'b0;
      src_o = 4'h0;
      pin_o = 1'b0;
   end
   always #1700 src_o[0] = ~src_o[0];
   always #900 src_o[1] = ~src_o[1];
   always #1300 src_o[2] = ~src_o[2];
   always #9700 src_o[3] = ~src_o[3];
   always #2300 pin_o = ~pin_o;
   // one word slot, kept or masked alike
   task send(input logic [31:0] w);
      begin
         @(posedge clk_i);
         stb_o <= 1'b1;
         word_o <= w;
         @(posedge clk_i);
         stb_o <= 1'b0;
         word_o <= ~w;
      end
   endtask
   task fend;
      begin
         @(posedge clk_i);
         fend_o <= 1'b1;
         @(posedge clk_i);
         fend_o <= 1'b0;
      end
   endtask
endmodule

// ---- sim/arx_top_sva.sv ----
// Purpose: port checker for arx_top
// Assumes: classic Wishbone master drops stb between accesses
// Notes: bound into arx_top below
`timescale 1ns/1ps
module arx_top_sva (
   input wire SYS_CLK_I,
   input wire SYS_RST_I,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [8:0] WB_ADR_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   input wire MCLK_O,
   input wire MCLK_OE_O
);
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   sequence rd_req;
      $rose(WB_STB_I) && !WB_WE_I && WB_ADR_I == 9'h0A0;
   endsequence
   sequence rd_wait;
      !WB_ACK_O ##1 !WB_ACK_O ##1 WB_ACK_O;
   endsequence
   a_rdata_wait: assert property (rd_req |-> rd_wait)
      else $error("receive data read not acked after one wait");
   a_reg_ack: assert property ($rose(WB_STB_I) && (WB_WE_I || WB_ADR_I != 9'h0A0)
      |-> !WB_ACK_O ##1 WB_ACK_O) else $error("register access ack late");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   a_dat_hold: assert property ($changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I)
      else $error("read data moved outside a read ack");
   a_oe_low: assert property (!MCLK_OE_O |-> !MCLK_O)
      else $error("divider output high while stopped");
   a_mctrl_resvd: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 9'h100
      |-> WB_DAT_O[29:26] == 4'h0) else $error("control reserved bits not zero");
   a_mask_resvd: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 9'h0E0
      |-> WB_DAT_O[31:2] == 30'h0) else $error("mask reserved bits not zero");
endmodule
bind arx_top arx_top_sva u_sva (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .MCLK_O(MCLK_O), .MCLK_OE_O(MCLK_OE_O));

// ---- sim/arx_top_tb_top.sv ----
// Purpose: self-checking bench for arx_top
// Assumes: classic single-cycle Wishbone master, all byte lanes on except one word mask write with none
// Notes: codec model feeds words and clock sources
`timescale 1ns/1ps
`include "arx_regs.vh"
module arx_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [8:0] adr = 9'h000;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'hF;
   logic [31:0] rdat, q, word;
   logic ack, rx_en, ch_en, mo, master_clock_output_enable, mint, irq, wstb, fend, pin;
   logic [3:0] src;
   integer err_count = 0;
   integer checks = 0;
   integer n, s;
   initial begin
      forever #50 clk = ~clk;
   end
   arx_codec_model u_codec (.clk_i(clk), .stb_o(wstb), .word_o(word), .fend_o(fend),
      .src_o(src), .pin_o(pin));
   arx_top u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .RX_WORD_STB_I(wstb), .RX_WORD_I(word), .RX_FRAME_END_I(fend),
      .RX_ENABLE_O(rx_en), .RX_CHAN_EN_O(ch_en), .MCLK_SRC_I(src), .MCLK_I(pin),
      .MCLK_O(mo), .MCLK_OE_O(master_clock_output_enable), .MCLK_INT_O(mint), .IRQ_O(irq));
   task wbs(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] m);
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= d;
         sel <= m;
         n = 0;
         @(posedge clk);
         while (ack !== 1'b1 && n < 40) begin
            @(posedge clk);
            n = n + 1;
         end
         if (ack !== 1'b1) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ack, 1'b1);
         end
         q = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
      end
   endtask
   task wb(input logic w, input logic [8:0] a, input logic [31:0] d);
      begin
         wbs(w, a, d, 4'hF);
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         checks = checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task rdc(input logic [8:0] a, input logic [31:0] e);
      begin
         wb(1'b0, a, 32'h0);
         chk(q, e);
      end
   endtask
   // poll control register until a bit reads zero
   task pollz(input integer b);
      begin
         s = 0;
         wb(1'b0, `ARX_OFF_MCTRL, 32'h0);
         while (q[b] !== 1'b0 && s < 600) begin
            wb(1'b0, `ARX_OFF_MCTRL, 32'h0);
            s = s + 1;
         end
      end
   endtask
   task test_done;
      begin
         $display("checks=%0d mismatches=%0d", checks, err_count);
         if (err_count == 0 && checks > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   initial begin
      #3000000;
      err_count = err_count + 1;
      test_done;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rdc(`ARX_OFF_WMASK, 32'h0);
      wb(1'b1, `ARX_OFF_WMASK, 32'hFFFFFFFF);
      rdc(`ARX_OFF_WMASK, 32'h3);
      wbs(1'b1, `ARX_OFF_WMASK, 32'h0, 4'h0);
      rdc(`ARX_OFF_WMASK, 32'h3);
      wb(1'b1, 9'h1F0, 32'hFFFFFFFF);
      rdc(9'h1F0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, `ARX_OFF_MCTRL, 32'(i) << 24);
         rdc(`ARX_OFF_MCTRL, 32'(i) << 24);
      end
      wb(1'b1, `ARX_OFF_MCTRL, 32'hFFFFFFFF);
      rdc(`ARX_OFF_MCTRL, 32'h43000000);
      chk({31'h0, master_clock_output_enable}, 32'h1);
      rdc(`ARX_OFF_MDIV, 32'h1);
      wb(1'b1, `ARX_OFF_MDIV, 32'h2);
      wb(1'b0, `ARX_OFF_MCTRL, 32'h0);
      chk({31'h0, q[31]}, 32'h1);
      wb(1'b1, `ARX_OFF_MDIV, 32'h9);
      rdc(`ARX_OFF_MDIV, 32'h2);
      pollz(31);
      chk({31'h0, q[31]}, 32'h0);
      chk({30'h0, mo, mint}, 32'h3);
      wb(1'b1, `ARX_OFF_MCTRL, 32'h0);
      pollz(30);
      chk(q, 32'h03000000);
      chk({31'h0, master_clock_output_enable}, 32'h0);
      @(pin);
      repeat (4) @(posedge clk);
      chk({31'h0, mint}, {31'h0, pin});
      wb(1'b1, `ARX_OFF_MDIV, 32'h3);
      rdc(`ARX_OFF_MCTRL, 32'h03000000);
      rdc(`ARX_OFF_MDIV, 32'h3);
      $display("test master clock done");
      wb(1'b1, `ARX_OFF_CFG3, 32'h1);
      wb(1'b1, `ARX_OFF_IMASK, 32'h1);
      wb(1'b1, `ARX_OFF_WMASK, 32'h2);
      wb(1'b1, `ARX_OFF_CTRL, 32'h1);
      chk({30'h0, rx_en, ch_en}, 32'h3);
      u_codec.send(32'hA5A50001);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rdc(`ARX_OFF_STAT, 32'h1);
      rdc(`ARX_OFF_RDATA, 32'hA5A50001);
      rdc(`ARX_OFF_RDATA, 32'h0);
      wb(1'b1, `ARX_OFF_STAT, 32'h1);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      u_codec.send(32'hB0B00002);
      rdc(`ARX_OFF_RDATA, 32'h0);
      u_codec.fend;
      wb(1'b1, `ARX_OFF_WMASK, 32'h1);
      u_codec.send(32'hC3C30003);
      rdc(`ARX_OFF_RDATA, 32'hC3C30003);
      u_codec.send(32'hD4D40004);
      rdc(`ARX_OFF_RDATA, 32'h0);
      u_codec.fend;
      u_codec.send(32'hE5E50005);
      rdc(`ARX_OFF_RDATA, 32'h0);
      u_codec.send(32'hF6F60006);
      rdc(`ARX_OFF_RDATA, 32'hF6F60006);
      wb(1'b1, `ARX_OFF_WMASK, 32'h0);
      u_codec.fend;
      u_codec.send(32'h11111111);
      u_codec.send(32'h22222222);
      rdc(`ARX_OFF_STAT, 32'h7);
      rdc(`ARX_OFF_RDATA, 32'h11111111);
      wb(1'b1, `ARX_OFF_IMASK, 32'h0);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      $display("test receive done");
      test_done;
   end
endmodule
